// ==== shared/mcs_pkg.sv ====
package mcs_pkg;
    localparam int          STATE_W        = 4;
    localparam int          MODE_W         = 4;
    localparam int          ADDR_W         = 24;
    localparam int          DATA_W         = 32;
    localparam int          CMD_W          = 8;
    localparam int          BIT_CNT_W      = 7;
    // serial frame: command byte, 24-bit address, 32-bit data, msb first
    localparam logic [6:0]  CMD_LAST_BIT   = 7'h07;
    localparam logic [6:0]  ADDR_LAST_BIT  = 7'h1F;
    localparam logic [6:0]  DATA_LAST_BIT  = 7'h3F;
    localparam logic [7:0]  CMD_WRITE      = 8'h02;
    localparam logic [7:0]  CMD_READ       = 8'h03;
    localparam logic [23:0] OPMODE_ADDR    = 24'h010604;
    localparam logic [3:0]  OPMODE_RESET   = 4'h0;
    localparam int          RD_MODE_LSB    = 0;
    localparam int          RD_STATE_LSB   = 8;
    localparam logic [3:0]  MODE_STANDBY   = 4'h0;
    localparam logic [3:0]  MODE_BRIDGE    = 4'h1;
    localparam logic [3:0]  MODE_BRIDGE_ALT = 4'h2;
    localparam logic [3:0]  MODE_SYMCIP    = 4'h3;
    localparam logic [3:0]  MODE_KEY_LOAD  = 4'h4;
    localparam logic [3:0]  MODE_RANDOM    = 4'h5;
    localparam logic [3:0]  MODE_EEPROM    = 4'h6;
    localparam logic [3:0]  MODE_HASH      = 4'h7;
    localparam logic [3:0]  MODE_PUF       = 4'h8;
    localparam logic [3:0]  MODE_ERASE     = 4'h9;
    localparam logic [3:0]  MODE_SLEEP     = 4'hA;
    localparam logic [3:0]  NUM_STATES     = 4'hE;

    typedef enum logic [STATE_W-1:0] {
        ST_MAIN_IDLE,
        ST_POWER_ON_LOAD,
        ST_RESET_FLAG_CHECK,
        ST_MAIN_STANDBY,
        ST_PROCESSOR_BRIDGE,
        ST_PROCESSOR_BRIDGE_ALT,
        ST_SYMMETRIC_CIPHER,
        ST_KEY_LOAD,
        ST_RANDOM_GEN,
        ST_EEPROM_ACCESS,
        ST_HASH_AUTH,
        ST_PUF_READ,
        ST_EEPROM_ERASE,
        ST_SLEEP_ENTRY
    } mcs_state_t;
endpackage

// ==== hw/mcs_spi_slave.sv ====
`timescale 1ns/100ps
module mcs_spi_slave (
    input  wire logic                       i_clk,
    input  wire logic                       i_reset_n,
    input  wire logic                       i_sck,
    input  wire logic                       i_cs_n,
    input  wire logic                       i_mosi,
    input  wire logic [mcs_pkg::DATA_W-1:0] i_rdata,
    output logic                            o_miso,
    output logic                            o_miso_oe,
    output logic                            o_wr_stb,
    output logic [mcs_pkg::ADDR_W-1:0]      o_addr,
    output logic [mcs_pkg::DATA_W-1:0]      o_wdata
);
    import mcs_pkg::*;

    logic [2:0]           sync1_reg, sync2_reg;
    logic                 sck_last_reg;
    logic [BIT_CNT_W-1:0] cnt_reg, cnt_next;
    logic [DATA_W-1:0]    shin_reg, shin_next, shout_reg, shout_next;
    logic [CMD_W-1:0]     cmd_reg, cmd_next;
    logic [ADDR_W-1:0]    addr_reg, addr_next;
    logic [DATA_W-1:0]    wdata_reg, wdata_next;
    logic                 load_reg, load_next, wr_reg, wr_next;
    logic                 miso_reg, miso_next, oe_reg, oe_next;
    logic                 sck, cs_n, mosi, rise, fall;

    // pins are asynchronous to i_clk; sck must stay below a quarter of i_clk
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1_reg    <= 3'h1;
            sync2_reg    <= 3'h1;
            sck_last_reg <= 1'b0;
        end else begin
            sync1_reg    <= {i_mosi, i_sck, i_cs_n};
            sync2_reg    <= sync1_reg;
            sck_last_reg <= sync2_reg[1];
        end
    end

    assign cs_n = sync2_reg[0];
    assign sck  = sync2_reg[1];
    assign mosi = sync2_reg[2];
    assign rise = sck && !sck_last_reg;
    assign fall = !sck && sck_last_reg;

    always_comb begin
        cnt_next   = cnt_reg;
        shin_next  = shin_reg;
        shout_next = shout_reg;
        cmd_next   = cmd_reg;
        addr_next  = addr_reg;
        wdata_next = wdata_reg;
        load_next  = 1'b0;
        wr_next    = 1'b0;
        miso_next  = miso_reg;
        oe_next    = oe_reg;
        if (cs_n) begin
            cnt_next = '0;
            oe_next  = 1'b0;
        end else begin
            if (load_reg) begin
                shout_next = i_rdata;
            end
            if (rise) begin
                shin_next = {shin_reg[DATA_W-2:0], mosi};
                cnt_next  = cnt_reg + 7'h01;
                if (cnt_reg == CMD_LAST_BIT) begin
                    cmd_next = {shin_reg[CMD_W-2:0], mosi};
                end
                if (cnt_reg == ADDR_LAST_BIT) begin
                    addr_next = {shin_reg[ADDR_W-2:0], mosi};
                    load_next = 1'b1;
                end
                if (cnt_reg == DATA_LAST_BIT && cmd_reg == CMD_WRITE) begin
                    wdata_next = {shin_reg[DATA_W-2:0], mosi};
                    wr_next    = 1'b1;
                end
            end
            // mode 0: data changes on the falling edge, ahead of the next rise
            if (fall && cmd_reg == CMD_READ && cnt_reg > ADDR_LAST_BIT && cnt_reg <= DATA_LAST_BIT) begin
                miso_next  = shout_reg[DATA_W-1];
                shout_next = {shout_reg[DATA_W-2:0], 1'b0};
                oe_next    = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_reg   <= '0;
            shin_reg  <= '0;
            shout_reg <= '0;
            cmd_reg   <= '0;
            addr_reg  <= '0;
            wdata_reg <= '0;
            load_reg  <= 1'b0;
            wr_reg    <= 1'b0;
            miso_reg  <= 1'b0;
            oe_reg    <= 1'b0;
        end else begin
            cnt_reg   <= cnt_next;
            shin_reg  <= shin_next;
            shout_reg <= shout_next;
            cmd_reg   <= cmd_next;
            addr_reg  <= addr_next;
            wdata_reg <= wdata_next;
            load_reg  <= load_next;
            wr_reg    <= wr_next;
            miso_reg  <= miso_next;
            oe_reg    <= oe_next;
        end
    end

    assign o_miso    = miso_reg;
    assign o_miso_oe = oe_reg;
    assign o_wr_stb  = wr_reg;
    assign o_addr    = addr_reg;
    assign o_wdata   = wdata_reg;
endmodule

// ==== hw/mcs_main_ctrl.sv ====
// What this block does
// - The controller runs one main state machine of fourteen states, each doing its own job.
// - After power-up or wake-up it walks from idle to standby by itself with no command.
// - On the way it passes a power-on load state that fetches the initial values, entered automatically.
// - A user setting lets it skip the reset-flag check state and go straight on.
// - When a function finishes the machine normally returns to standby.
// - Only an operating-mode write over the serial link selects the processor bridge state.
// - Only an operating-mode write over the serial link selects the symmetric cipher state.
// - Symmetric cipher work is enabled only while in the symmetric cipher state.
// - Sleep turns the internal oscillator off, halting the controller until wake-up.
// - Control accesses arrive over the slave serial link of the cipher section.
`timescale 1ns/100ps
module mcs_main_ctrl (
    input  wire logic                        i_clk,
    input  wire logic                        i_reset_n,
    input  wire logic                        i_sck,
    input  wire logic                        i_cs_n,
    input  wire logic                        i_mosi,
    input  wire logic                        i_rsflag_check_skip,
    input  wire logic                        i_pon_load_done,
    input  wire logic                        i_rsflag_check_done,
    input  wire logic                        i_func_done,
    output logic                             o_miso,
    output logic                             o_miso_oe,
    output logic [mcs_pkg::STATE_W-1:0]      o_main_state,
    output logic                             o_symcip_en,
    output logic                             o_bridge_sel,
    output logic                             o_bridge_alt_sel,
    output logic                             o_pon_load_req,
    output logic                             o_rsflag_check_req,
    output logic                             o_func_active,
    output logic                             o_osc_en
);
    import mcs_pkg::*;

    logic                skip_s1_reg, skip_s2_reg;
    logic                spi_wr;
    logic [ADDR_W-1:0]   spi_addr;
    logic [DATA_W-1:0]   spi_wdata, rdata;
    logic                opmode_wr;
    logic [MODE_W-1:0]   wr_code;
    mcs_state_t          state_reg, state_next;
    logic [MODE_W-1:0]   mode_reg, mode_next;
    logic                symcip_reg, bridge_reg, bridge_alt_reg, pon_reg, chk_reg, func_reg, osc_reg;

    mcs_spi_slave u_link (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_sck     (i_sck),
        .i_cs_n    (i_cs_n),
        .i_mosi    (i_mosi),
        .i_rdata   (rdata),
        .o_miso    (o_miso),
        .o_miso_oe (o_miso_oe),
        .o_wr_stb  (spi_wr),
        .o_addr    (spi_addr),
        .o_wdata   (spi_wdata)
    );

    // skip strap comes from a pin
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            skip_s1_reg <= 1'b0;
            skip_s2_reg <= 1'b0;
        end else begin
            skip_s1_reg <= i_rsflag_check_skip;
            skip_s2_reg <= skip_s1_reg;
        end
    end

    assign opmode_wr = spi_wr && (spi_addr == OPMODE_ADDR);
    assign wr_code   = spi_wdata[MODE_W-1:0];

    // unmapped addresses read zero; state shown beside the stored mode
    always_comb begin
        rdata = '0;
        if (spi_addr == OPMODE_ADDR) begin
            rdata[RD_MODE_LSB +: MODE_W]   = mode_reg;
            rdata[RD_STATE_LSB +: STATE_W] = state_reg;
        end
    end

    function automatic mcs_state_t mode_to_state(input logic [MODE_W-1:0] code);
        unique case (code)
            MODE_BRIDGE:     mode_to_state = ST_PROCESSOR_BRIDGE;
            MODE_BRIDGE_ALT: mode_to_state = ST_PROCESSOR_BRIDGE_ALT;
            MODE_SYMCIP:     mode_to_state = ST_SYMMETRIC_CIPHER;
            MODE_KEY_LOAD:   mode_to_state = ST_KEY_LOAD;
            MODE_RANDOM:     mode_to_state = ST_RANDOM_GEN;
            MODE_EEPROM:     mode_to_state = ST_EEPROM_ACCESS;
            MODE_HASH:       mode_to_state = ST_HASH_AUTH;
            MODE_PUF:        mode_to_state = ST_PUF_READ;
            MODE_ERASE:      mode_to_state = ST_EEPROM_ERASE;
            MODE_SLEEP:      mode_to_state = ST_SLEEP_ENTRY;
            default:         mode_to_state = ST_MAIN_STANDBY;
        endcase
    endfunction

    always_comb begin
        state_next = state_reg;
        mode_next  = mode_reg;
        if (opmode_wr) begin
            mode_next = wr_code;
        end
        unique case (state_reg)
            ST_MAIN_IDLE: begin
                state_next = ST_POWER_ON_LOAD;
            end
            ST_POWER_ON_LOAD: begin
                if (i_pon_load_done) begin
                    state_next = skip_s2_reg ? ST_MAIN_STANDBY : ST_RESET_FLAG_CHECK;
                end
            end
            ST_RESET_FLAG_CHECK: begin
                if (i_rsflag_check_done) begin
                    state_next = ST_MAIN_STANDBY;
                end
            end
            ST_MAIN_STANDBY: begin
                // hardware never picks bridge or cipher itself
                if (opmode_wr) begin
                    state_next = mode_to_state(wr_code);
                end
            end
            ST_PROCESSOR_BRIDGE, ST_PROCESSOR_BRIDGE_ALT, ST_SYMMETRIC_CIPHER: begin
                if (opmode_wr && wr_code == MODE_STANDBY) begin
                    state_next = ST_MAIN_STANDBY;
                end
            end
            ST_SLEEP_ENTRY: begin
                // clock stops once the oscillator is off; wake-up comes through reset
                state_next = ST_SLEEP_ENTRY;
            end
            default: begin
                if (i_func_done || (opmode_wr && wr_code == MODE_STANDBY)) begin
                    state_next = ST_MAIN_STANDBY;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg      <= ST_MAIN_IDLE;
            mode_reg       <= OPMODE_RESET;
            symcip_reg     <= 1'b0;
            bridge_reg     <= 1'b0;
            bridge_alt_reg <= 1'b0;
            pon_reg        <= 1'b0;
            chk_reg        <= 1'b0;
            func_reg       <= 1'b0;
            osc_reg        <= 1'b1;
        end else begin
            state_reg      <= state_next;
            mode_reg       <= mode_next;
            symcip_reg     <= (state_next == ST_SYMMETRIC_CIPHER);
            bridge_reg     <= (state_next == ST_PROCESSOR_BRIDGE);
            bridge_alt_reg <= (state_next == ST_PROCESSOR_BRIDGE_ALT);
            pon_reg        <= (state_next == ST_POWER_ON_LOAD);
            chk_reg        <= (state_next == ST_RESET_FLAG_CHECK);
            func_reg       <= (state_next >= ST_KEY_LOAD) && (state_next <= ST_EEPROM_ERASE);
            osc_reg        <= (state_next != ST_SLEEP_ENTRY);
        end
    end

    assign o_main_state       = state_reg;
    assign o_symcip_en        = symcip_reg;
    assign o_bridge_sel       = bridge_reg;
    assign o_bridge_alt_sel   = bridge_alt_reg;
    assign o_pon_load_req     = pon_reg;
    assign o_rsflag_check_req = chk_reg;
    assign o_func_active      = func_reg;
    assign o_osc_en           = osc_reg;

    a_state_in_range: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_main_state < NUM_STATES) else $error("main state out of range");
    a_idle_to_load: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        state_reg == ST_MAIN_IDLE |=> state_reg == ST_POWER_ON_LOAD ##0 o_pon_load_req)
        else $error("idle did not start power-on load");
    a_load_to_check: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        state_reg == ST_POWER_ON_LOAD && i_pon_load_done && !skip_s2_reg |=> o_rsflag_check_req)
        else $error("power-on load did not reach flag check");
    a_check_skipped: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        state_reg == ST_POWER_ON_LOAD && i_pon_load_done && skip_s2_reg |=> state_reg == ST_MAIN_STANDBY)
        else $error("flag check skip ignored");
    a_func_returns: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_func_active && i_func_done |=> state_reg == ST_MAIN_STANDBY && !o_func_active)
        else $error("function did not return to standby");
    a_bridge_by_write: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !o_bridge_sel ##1 o_bridge_sel |-> $past(opmode_wr) && $past(wr_code) == MODE_BRIDGE)
        else $error("bridge entered without mode write");
    a_symcip_by_write: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $rose(state_reg == ST_SYMMETRIC_CIPHER) |-> $past(opmode_wr) && $past(wr_code) == MODE_SYMCIP)
        else $error("cipher state entered without mode write");
    a_symcip_gate: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_symcip_en == (state_reg == ST_SYMMETRIC_CIPHER)) else $error("cipher enable outside its state");
    a_sleep_osc_off: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        state_reg == ST_SLEEP_ENTRY |-> !o_osc_en) else $error("oscillator left on in sleep");
    a_mode_stored: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        opmode_wr |=> mode_reg == $past(wr_code)) else $error("mode write not stored");
    a_standby_select: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        state_reg == ST_MAIN_STANDBY && opmode_wr && wr_code == MODE_SYMCIP |=> o_symcip_en)
        else $error("standby ignored cipher selection");

    c_init_done: cover property (@(posedge i_clk) disable iff (!i_reset_n)
        state_reg == ST_RESET_FLAG_CHECK ##1 state_reg == ST_MAIN_STANDBY);
    c_symcip_round: cover property (@(posedge i_clk) disable iff (!i_reset_n)
        o_symcip_en ##[1:1000] state_reg == ST_MAIN_STANDBY);
    c_bridge: cover property (@(posedge i_clk) disable iff (!i_reset_n) o_bridge_sel);
    c_sleep: cover property (@(posedge i_clk) disable iff (!i_reset_n) !o_osc_en);
endmodule

// ==== verification/mcs_host_model.sv ====
`timescale 1ns/100ps
module mcs_host_model (
    input  wire logic i_clk,
    input  wire logic i_miso,
    output logic      o_sck,
    output logic      o_cs_n,
    output logic      o_mosi
);
    import mcs_pkg::*;
    // half sck period in i_clk cycles: read data lands ~3 clk after a fall, so 2 is too tight
    localparam int HALF = 6;

    initial begin
        o_sck  = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b1;
    end

    task automatic half_wait();
        repeat (HALF) @(negedge i_clk);
    endtask

    // mode 0 frame: drive while sck low, device samples on the rise
    task automatic frame(input logic [7:0] cmd, input logic [23:0] addr, input logic [31:0] wdata,
                         output logic [31:0] rdata);
        logic [63:0] sh;
        sh = {cmd, addr, wdata};
        rdata = 32'h0;
        @(negedge i_clk);
        o_cs_n = 1'b0;
        for (int i = 63; i >= 0; i--) begin
            o_mosi = sh[i];
            half_wait();
            o_sck = 1'b1;
            if (i < 32) begin
                rdata = {rdata[30:0], i_miso};
            end
            half_wait();
            o_sck = 1'b0;
        end
        half_wait();
        o_cs_n = 1'b1;
        // released line must not keep the last bit
        o_mosi = ~o_mosi;
        repeat (8) @(negedge i_clk);
    endtask

    // the only way into bridge, cipher, or back to standby after a held function
    task automatic set_mode(input logic [3:0] code);
        logic [31:0] dummy;
        frame(CMD_WRITE, OPMODE_ADDR, {28'h0, code}, dummy);
    endtask
endmodule

// ==== verification/mcs_main_ctrl_tb.sv ====
`timescale 1ns/100ps
module mcs_main_ctrl_tb;
    import mcs_pkg::*;
    logic               i_clk;
    logic               i_reset_n;
    logic               rs_skip;
    logic               pon_done;
    logic               rs_done;
    logic               func_done;
    logic               sck;
    logic               cs_n;
    logic               mosi;
    logic               miso;
    logic               miso_oe;
    logic [STATE_W-1:0] main_state;
    logic               symcip_en;
    logic               bridge_sel;
    logic               bridge_alt_sel;
    logic               pon_req;
    logic               rs_req;
    logic               func_active;
    logic               osc_en;
    logic [31:0]        rd;
    int                 n_errors    = 0;
    int                 comparisons = 0;
    int                 cycles      = 0;

    mcs_main_ctrl u_mcs_main_ctrl (
        .i_clk               (i_clk),
        .i_reset_n           (i_reset_n),
        .i_sck               (sck),
        .i_cs_n              (cs_n),
        .i_mosi              (mosi),
        .i_rsflag_check_skip (rs_skip),
        .i_pon_load_done     (pon_done),
        .i_rsflag_check_done (rs_done),
        .i_func_done         (func_done),
        .o_miso              (miso),
        .o_miso_oe           (miso_oe),
        .o_main_state        (main_state),
        .o_symcip_en         (symcip_en),
        .o_bridge_sel        (bridge_sel),
        .o_bridge_alt_sel    (bridge_alt_sel),
        .o_pon_load_req      (pon_req),
        .o_rsflag_check_req  (rs_req),
        .o_func_active       (func_active),
        .o_osc_en            (osc_en)
    );

    mcs_host_model u_mcs_host_model (
        .i_clk  (i_clk),
        .i_miso (miso),
        .o_sck  (sck),
        .o_cs_n (cs_n),
        .o_mosi (mosi)
    );

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    task automatic wrap_up();
        if (n_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // whole run is ~30 frames of ~780 cycles
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_errors = n_errors + 1;
            wrap_up();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic chk_st(input logic [3:0] exp);
        check({28'h0, main_state}, {28'h0, exp});
    endtask

    // {osc, cipher, bridge, bridge_alt, func, load, flag_check}; miso_oe must be low between frames
    task automatic chk_fl(input logic [6:0] exp);
        check({24'h0, miso_oe, osc_en, symcip_en, bridge_sel, bridge_alt_sel, func_active, pon_req, rs_req},
              {25'h0, exp});
    endtask

    task automatic pulse_done();
        func_done = 1'b1;
        @(negedge i_clk);
        func_done = 1'b0;
        repeat (2) @(negedge i_clk);
    endtask

    task automatic t_init(input logic skip);
        @(negedge i_clk);
        i_reset_n = 1'b0;
        rs_skip   = skip;
        repeat (3) @(negedge i_clk);
        chk_st(ST_MAIN_IDLE);
        chk_fl(7'h40);
        i_reset_n = 1'b1;
        @(negedge i_clk);
        chk_st(ST_POWER_ON_LOAD);
        chk_fl(7'h42);
        if (!skip) begin
            u_mcs_host_model.set_mode(MODE_SYMCIP);
            chk_st(ST_POWER_ON_LOAD);
            u_mcs_host_model.set_mode(MODE_STANDBY);
        end
        // skip strap needs two clocks through its synchroniser
        repeat (2) @(negedge i_clk);
        pon_done = 1'b1;
        @(negedge i_clk);
        pon_done = 1'b0;
        if (skip) begin
            chk_st(ST_MAIN_STANDBY);
        end else begin
            chk_st(ST_RESET_FLAG_CHECK);
            chk_fl(7'h41);
            repeat (3) @(negedge i_clk);
            chk_st(ST_RESET_FLAG_CHECK);
            rs_done = 1'b1;
            @(negedge i_clk);
            rs_done = 1'b0;
            chk_st(ST_MAIN_STANDBY);
        end
        chk_fl(7'h40);
    endtask

    task automatic t_select(input logic [3:0] code, input logic [3:0] st, input logic [6:0] fl);
        u_mcs_host_model.set_mode(code);
        chk_st(st);
        chk_fl(fl);
        pulse_done();
        chk_st(st);
        u_mcs_host_model.set_mode(MODE_STANDBY);
        chk_st(ST_MAIN_STANDBY);
        chk_fl(7'h40);
    endtask

    task automatic t_functions();
        logic [3:0] code;
        logic [3:0] st;
        for (int k = 0; k < 6; k++) begin
            code = MODE_KEY_LOAD + 4'(k);
            st   = 4'(ST_KEY_LOAD) + 4'(k);
            u_mcs_host_model.set_mode(code);
            chk_st(st);
            chk_fl(7'h44);
            u_mcs_host_model.frame(CMD_READ, OPMODE_ADDR, 32'h0, rd);
            check(rd, {20'h0, st, 4'h0, code});
            if (k[0]) begin
                pulse_done();
            end else begin
                u_mcs_host_model.set_mode(MODE_STANDBY);
            end
            chk_st(ST_MAIN_STANDBY);
        end
    endtask

    task automatic t_refused();
        u_mcs_host_model.set_mode(4'hB);
        chk_st(ST_MAIN_STANDBY);
        u_mcs_host_model.set_mode(4'hF);
        chk_st(ST_MAIN_STANDBY);
        // wrong command byte, then right command to a neighbour address
        u_mcs_host_model.frame(8'h05, OPMODE_ADDR, {28'h0, MODE_SYMCIP}, rd);
        chk_st(ST_MAIN_STANDBY);
        u_mcs_host_model.frame(CMD_WRITE, 24'h010600, {28'h0, MODE_BRIDGE}, rd);
        chk_st(ST_MAIN_STANDBY);
        u_mcs_host_model.frame(CMD_READ, 24'h010600, 32'h0, rd);
        check(rd, 32'h0);
        u_mcs_host_model.set_mode(MODE_STANDBY);
        u_mcs_host_model.frame(CMD_READ, OPMODE_ADDR, 32'h0, rd);
        check(rd, 32'h0000_0300);
    endtask

    task automatic t_sleep();
        u_mcs_host_model.set_mode(MODE_SLEEP);
        chk_st(ST_SLEEP_ENTRY);
        chk_fl(7'h00);
        pulse_done();
        chk_st(ST_SLEEP_ENTRY);
        t_init(1'b1);
    endtask

    initial begin
        i_reset_n = 1'b0;
        rs_skip   = 1'b0;
        pon_done  = 1'b0;
        rs_done   = 1'b0;
        func_done = 1'b0;
        t_init(1'b0);
        t_select(MODE_BRIDGE, ST_PROCESSOR_BRIDGE, 7'h50);
        t_select(MODE_BRIDGE_ALT, ST_PROCESSOR_BRIDGE_ALT, 7'h48);
        t_select(MODE_SYMCIP, ST_SYMMETRIC_CIPHER, 7'h60);
        t_functions();
        t_refused();
        t_sleep();
        wrap_up();
    end
endmodule
